// ==== seq_pkg.sv ====
/*
  Shared constants, types and timing for the isolated supply sequencer.
  Assumes a single 250 MHz controller clock; sensed levels are comparator outputs apart from the setpoint select strap.
*/
package seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TON_MAX_NS = 13000;
  localparam int TOFF_MIN_NS = 1500;
  localparam int FAULT_PULSE_US = 200;
  localparam int RESTART_MS = 160;
  // Longest on-time rounds down, least off-time and pulse/wait round up
  localparam int TON_MAX_CYC = TON_MAX_NS * CLK_MHZ / 1000;
  localparam int TOFF_MIN_CYC = (TOFF_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
  localparam int DEGLITCH_CYC = 256;
  // Cycles the pin is still ignored after the sink releases it
  localparam int BLANK_CYC = 3;
  localparam int SWEEP_W = 4;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic RST_IN_BAD = 1'b1;
  localparam logic RST_SETPOINT_5V5 = 1'b0;
  localparam logic RST_FAULT_LEVEL = 1'b0;
  localparam logic SEL_TIED_OUTPUT = 1'b1;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LOCK,
    ST_SOFT,
    ST_RUN,
    ST_LIMIT,
    ST_PULSE,
    ST_WAIT
  } state_t;

  typedef struct packed {
    logic out_above_upper;
    logic out_below_lower;
    logic out_above_uvlo;
    logic out_below_uvp;
    logic output_overvolt_rising;
    logic input_undervolt_falling;
    logic input_undervolt_rising;
    logic input_overvolt_rising;
    logic input_overvolt_falling;
    logic primary_overtemp_threshold;
    logic secondary_overtemp_threshold;
    logic setpoint_sel;
  } sense_t;

  typedef struct packed {
    logic power_on;
    logic duty_limit;
    logic clamp;
    logic overpower;
  } stage_t;

endpackage

// ==== sync2.sv ====
/*
  Two-stage synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== deglitch_timer.sv ====
/*
  Qualifies a fault condition that must persist for CYC cycles.
  Assumes cond is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
module deglitch_timer #(
  parameter int CYC = 256
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Condition in, qualified level out
  input wire logic cond,
  output logic expired_q
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt_q;

  generate
    if (CYC < 1) begin : g_bad
      $error("deglitch CYC must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= '0;
      expired_q <= 1'b0;
    end else if (ce) begin
      if (!cond) begin
        cnt_q <= '0;
        expired_q <= 1'b0;
      end else if (cnt_q == LAST) begin
        expired_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_deglitch_restart: assert property (ce && !cond |=> !expired_q && cnt_q == '0)
    else $error("deglitch did not restart");
  chk_deglitch_expire: assert property (ce && cond && cnt_q == LAST |=> expired_q)
    else $error("deglitch did not expire");
endmodule

// ==== isolated_supply_fault_sequencer.sv ====
/*
  Control and protection sequencer of an isolated DC/DC module.
  Assumes comparator levels and the shared pin are asynchronous; pin level is resolved outside.
*/
// Function
// - Hysteretic burst on below band, off above
// - Overlong burst-on enters overpower protection
// - Overpower restarts burst after minimum off-time
// - Setpoint sampled only in soft-start below UVLO
// - Select high gives 5.0V, low gives 5.5V
// - Setpoint locked until enable toggle or input undervolt/overvolt lockout
// - Input undervolt or overvolt stops switching
// - Input back in range resumes immediately
// - Output undervolt: duty limit, then deglitched shutdown
// - Output overvolt: clamp, limit, shutdown, restart
// - Overtemperature: deglitched shutdown, report, restart
// - Input OV, OT, UV shutdown pulse the pin
// - Restart timer after pulse, then hiccup soft-start
// - Frequency sweep restarts every burst; it spans fully only if the burst lasts 15 step periods set by the last burst
// - Pin low disables, high enables
// - Duty cap during soft-start and limit mode
// - Fault pulse holds pin low 200us
`timescale 1ns/1ps
module isolated_supply_fault_sequencer #(
  parameter int FAULT_PULSE_CYC = seq_pkg::FAULT_PULSE_CYC,
  parameter int RESTART_CYC = seq_pkg::RESTART_CYC,
  parameter int DEGLITCH_CYC = seq_pkg::DEGLITCH_CYC
) (
  // Clock, reset, clock enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Asynchronous comparator and strap levels
  input wire seq_pkg::sense_t sense_raw,
  // Shared enable and fault pin
  input wire logic enable_fault_line_i,
  output logic enable_fault_line_o,
  output logic enable_fault_line_oe,
  // Power stage and status
  output seq_pkg::stage_t stage,
  output logic setpoint_5v5,
  output logic [seq_pkg::SWEEP_W-1:0] spread_spectrum_sweep,
  output seq_pkg::state_t seq_state
);
  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int SW = $bits(seq_pkg::sense_t) + 1;
  localparam int ON_W = $clog2(seq_pkg::TON_MAX_CYC + 1);
  localparam int OFF_W = $clog2(seq_pkg::TOFF_MIN_CYC + 1);
  localparam int FP_W = $clog2(FAULT_PULSE_CYC + 1);
  localparam int RS_W = $clog2(RESTART_CYC + 1);
  localparam logic [ON_W-1:0] ON_LAST = ON_W'(seq_pkg::TON_MAX_CYC - 1);
  localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(seq_pkg::TOFF_MIN_CYC - 1);
  localparam logic [FP_W-1:0] FP_LAST = FP_W'(FAULT_PULSE_CYC - 1);
  localparam logic [RS_W-1:0] RS_LAST = RS_W'(RESTART_CYC - 1);
  localparam logic [seq_pkg::SWEEP_W-1:0] SWEEP_TOP = '1;

  generate
    if (FAULT_PULSE_CYC < 2 || RESTART_CYC < 2 || DEGLITCH_CYC < 1) begin : g_bad
      $error("timer counts too small");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [SW-1:0] sync_q;
  seq_pkg::sense_t sn;
  logic en_line;

  sync2 #(.W(SW)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .d({enable_fault_line_i, sense_raw}),
    .q(sync_q)
  );
  assign sn = seq_pkg::sense_t'(sync_q[SW-2:0]);
  assign en_line = sync_q[SW-1];

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  seq_pkg::state_t state_q, state_d;
  seq_pkg::stage_t stage_q, stage_d;
  logic in_bad_q, in_ov_q, sink_q, sel_done_q, sp_q, fault_o_q;
  logic [seq_pkg::BLANK_CYC-1:0] hist_q;
  logic [ON_W-1:0] on_cnt_q, len_q, step_q;
  logic [OFF_W-1:0] off_cnt_q;
  logic [FP_W-1:0] fp_cnt_q;
  logic [RS_W-1:0] rs_cnt_q;
  logic [seq_pkg::SWEEP_W-1:0] sweep_q;
  logic en_low, active, reg_mode, uv_cond, ov_cond, ot_cond, uv_exp, ov_exp, ot_exp;
  logic in_bad_d, in_ov_rise, pulse_go, fp_done, rs_done, sel_window;
  logic end_hi, on_timeout, off_done, burst_start, pwr_rise, pwr_fall, sweep_tick;

  // Our own sink pulls the pin low; blank it so a report is not read as disable
  assign en_low = !en_line && !sink_q && !(|hist_q);
  assign active = state_q == seq_pkg::ST_SOFT || state_q == seq_pkg::ST_RUN || state_q == seq_pkg::ST_LIMIT;
  assign reg_mode = state_q == seq_pkg::ST_RUN || state_q == seq_pkg::ST_LIMIT;
  assign uv_cond = reg_mode && sn.out_below_uvp;
  assign ov_cond = active && sn.output_overvolt_rising;
  assign ot_cond = active && (sn.primary_overtemp_threshold || sn.secondary_overtemp_threshold);
  assign in_bad_d = (sn.input_undervolt_falling || sn.input_overvolt_rising) ? 1'b1 :
                    (sn.input_undervolt_rising && sn.input_overvolt_falling) ? 1'b0 : in_bad_q;
  assign in_ov_rise = sn.input_overvolt_rising && !in_ov_q && state_q != seq_pkg::ST_OFF;
  assign pulse_go = in_ov_rise || (state_d == seq_pkg::ST_PULSE && state_q != seq_pkg::ST_PULSE);
  assign fp_done = sink_q && fp_cnt_q == FP_LAST;
  assign rs_done = rs_cnt_q == RS_LAST;
  assign sel_window = state_q == seq_pkg::ST_SOFT && !sn.out_above_uvlo && !sel_done_q;

  deglitch_timer #(.CYC(DEGLITCH_CYC)) u_dg_uv (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .cond(uv_cond), .expired_q(uv_exp));
  deglitch_timer #(.CYC(DEGLITCH_CYC)) u_dg_ov (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .cond(ov_cond), .expired_q(ov_exp));
  deglitch_timer #(.CYC(DEGLITCH_CYC)) u_dg_ot (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .cond(ot_cond), .expired_q(ot_exp));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (en_low) begin
      state_d = seq_pkg::ST_OFF;
    end else if (in_bad_q) begin
      state_d = seq_pkg::ST_LOCK;
    end else begin
      case (state_q)
        seq_pkg::ST_OFF, seq_pkg::ST_LOCK: state_d = seq_pkg::ST_SOFT;
        seq_pkg::ST_SOFT: begin
          if (ot_exp) state_d = seq_pkg::ST_PULSE;
          else if (ov_exp) state_d = seq_pkg::ST_WAIT;
          else if (ov_cond) state_d = seq_pkg::ST_LIMIT;
          else if (sn.out_above_uvlo) state_d = seq_pkg::ST_RUN;
        end
        seq_pkg::ST_RUN: begin
          if (ot_exp) state_d = seq_pkg::ST_PULSE;
          else if (uv_cond || ov_cond) state_d = seq_pkg::ST_LIMIT;
        end
        seq_pkg::ST_LIMIT: begin
          if (ot_exp || uv_exp) state_d = seq_pkg::ST_PULSE;
          else if (ov_exp) state_d = seq_pkg::ST_WAIT;
          else if (!uv_cond && !ov_cond) state_d = seq_pkg::ST_RUN;
        end
        seq_pkg::ST_PULSE: if (!sink_q) state_d = seq_pkg::ST_WAIT;
        seq_pkg::ST_WAIT: if (rs_done) state_d = seq_pkg::ST_SOFT;
        default: state_d = seq_pkg::ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Burst regulation and overpower
  // ----------------------------------------------------------------
  assign end_hi = stage_q.power_on && sn.out_above_upper;
  assign on_timeout = stage_q.power_on && !sn.out_above_upper && on_cnt_q == ON_LAST;
  assign off_done = stage_q.overpower && off_cnt_q == OFF_LAST && !sn.out_above_upper;
  assign burst_start = stage_q.overpower ? off_done : sn.out_below_lower;
  assign stage_d.power_on = state_q == seq_pkg::ST_SOFT ||
                            (reg_mode && (stage_q.power_on ? !(end_hi || on_timeout) : burst_start));
  assign stage_d.overpower = reg_mode && (on_timeout || (stage_q.overpower && !sn.out_above_upper));
  assign stage_d.duty_limit = state_q == seq_pkg::ST_SOFT || state_q == seq_pkg::ST_LIMIT;
  assign stage_d.clamp = ov_cond;
  assign pwr_rise = !stage_q.power_on && stage_d.power_on;
  assign pwr_fall = stage_q.power_on && !stage_d.power_on;
  // Step period adapts to the last burst; a burst shorter than 15 such periods ends below the top of the span
  assign sweep_tick = step_q >= (len_q >> seq_pkg::SWEEP_W);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage_q <= '0;
      on_cnt_q <= '0;
      off_cnt_q <= '0;
    end else if (ce) begin
      stage_q <= stage_d;
      on_cnt_q <= !stage_q.power_on ? '0 : (on_cnt_q == ON_LAST ? on_cnt_q : on_cnt_q + 1'b1);
      off_cnt_q <= stage_q.power_on ? '0 : (off_cnt_q == OFF_LAST ? off_cnt_q : off_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      len_q <= '0;
      step_q <= '0;
      sweep_q <= '0;
    end else if (ce) begin
      if (pwr_fall) len_q <= on_cnt_q;
      if (pwr_rise) begin
        step_q <= '0;
        sweep_q <= '0;
      end else if (stage_q.power_on) begin
        step_q <= sweep_tick ? '0 : step_q + 1'b1;
        if (sweep_tick && sweep_q != SWEEP_TOP) sweep_q <= sweep_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state, setpoint, fault pulse and restart timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= seq_pkg::ST_OFF;
      in_bad_q <= seq_pkg::RST_IN_BAD;
      in_ov_q <= 1'b0;
      sel_done_q <= 1'b0;
      sp_q <= seq_pkg::RST_SETPOINT_5V5;
    end else if (ce) begin
      state_q <= state_d;
      in_bad_q <= in_bad_d;
      in_ov_q <= sn.input_overvolt_rising;
      // Disable or input undervolt/overvolt lockout re-arms selection
      if (state_q == seq_pkg::ST_OFF || state_q == seq_pkg::ST_LOCK) sel_done_q <= 1'b0;
      else if (state_q == seq_pkg::ST_SOFT && sn.out_above_uvlo) sel_done_q <= 1'b1;
      if (sel_window) sp_q <= sn.setpoint_sel != seq_pkg::SEL_TIED_OUTPUT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sink_q <= 1'b0;
      fp_cnt_q <= '0;
      hist_q <= '0;
      rs_cnt_q <= '0;
      fault_o_q <= seq_pkg::RST_FAULT_LEVEL;
    end else if (ce) begin
      hist_q <= {hist_q[seq_pkg::BLANK_CYC-2:0], sink_q};
      fault_o_q <= seq_pkg::RST_FAULT_LEVEL;
      if (pulse_go) begin
        sink_q <= 1'b1;
        fp_cnt_q <= '0;
      end else if (fp_done) begin
        sink_q <= 1'b0;
      end else if (sink_q) begin
        fp_cnt_q <= fp_cnt_q + 1'b1;
      end
      rs_cnt_q <= (state_q == seq_pkg::ST_WAIT && !rs_done) ? rs_cnt_q + 1'b1 : '0;
    end
  end

  assign enable_fault_line_o = fault_o_q;
  assign enable_fault_line_oe = sink_q;
  assign stage = stage_q;
  assign setpoint_5v5 = sp_q;
  assign spread_spectrum_sweep = sweep_q;
  assign seq_state = state_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic stay_reg;
  assign stay_reg = reg_mode && state_d == state_q;

  chk_burst_upper_stop: assert property (ce && stay_reg && end_hi |=> !stage_q.power_on)
    else $error("burst did not stop at upper band");
  chk_burst_lower_start: assert property (ce && stay_reg && !stage_q.power_on && !stage_q.overpower
      && sn.out_below_lower |=> stage_q.power_on)
    else $error("burst did not start at lower band");
  chk_opp_enter: assert property (ce && stay_reg && on_timeout |=> stage_q.overpower && !stage_q.power_on)
    else $error("overpower not entered on long burst");
  chk_opp_restart: assert property (ce && stay_reg && !stage_q.power_on && off_done |=> stage_q.power_on)
    else $error("overpower burst not restarted");
  chk_sel_sample: assert property (ce && sel_window |=> sp_q == ($past(sn.setpoint_sel) != seq_pkg::SEL_TIED_OUTPUT))
    else $error("setpoint not sampled");
  chk_sel_locked: assert property (ce && !sel_window |=> $stable(sp_q))
    else $error("setpoint changed outside sampling window");
  chk_sel_done_hold: assert property (ce && sel_done_q && active |=> sel_done_q)
    else $error("setpoint lock dropped while running");
  chk_input_lock: assert property (ce && in_bad_q && !en_low |=> state_q == seq_pkg::ST_LOCK)
    else $error("input fault did not lock out");
  chk_lock_resume: assert property (ce && state_q == seq_pkg::ST_LOCK && !in_bad_q && !en_low
      |=> state_q == seq_pkg::ST_SOFT)
    else $error("no immediate resume after input recovers");
  chk_uv_limit: assert property (ce && state_q == seq_pkg::ST_RUN && uv_cond && !ot_exp && !en_low && !in_bad_q
      |=> state_q == seq_pkg::ST_LIMIT ##1 stage_q.duty_limit || !ce)
    else $error("undervolt did not enter limit mode");
  chk_overvoltage_clamp: assert property (ce && ov_cond |=> stage_q.clamp)
    else $error("overvolt clamp not driven");
  chk_ot_stop: assert property (ce && ot_exp && state_q == seq_pkg::ST_RUN && !en_low && !in_bad_q
      |=> state_q == seq_pkg::ST_PULSE && sink_q)
    else $error("overtemp did not shut down and report");
  chk_pulse_start: assert property (ce && pulse_go |=> sink_q && fp_cnt_q == '0)
    else $error("fault pulse not started");
  chk_pulse_hold: assert property (ce && sink_q && !fp_done |=> sink_q)
    else $error("fault pulse ended early");
  chk_pulse_end: assert property (ce && fp_done && !pulse_go |=> !sink_q)
    else $error("fault pulse overran");
  chk_hiccup: assert property (ce && state_q == seq_pkg::ST_WAIT && rs_done && !en_low && !in_bad_q
      |=> state_q == seq_pkg::ST_SOFT)
    else $error("restart timer did not start soft-start");
  chk_sweep_reset: assert property (ce && pwr_rise |=> sweep_q == '0)
    else $error("sweep not restarted at burst start");
  chk_disable: assert property (ce && en_low |=> state_q == seq_pkg::ST_OFF)
    else $error("pin low did not disable");
  chk_soft_cap: assert property (ce && state_q == seq_pkg::ST_SOFT |=> stage_q.duty_limit)
    else $error("duty cap missing in soft-start");

  cov_overpower: cover property (ce && on_timeout ##1 stage_q.overpower);
  cov_fault_pulse: cover property (ce && pulse_go ##1 sink_q);
  cov_hiccup: cover property (state_q == seq_pkg::ST_WAIT ##1 state_q == seq_pkg::ST_SOFT);
  cov_input_lock: cover property (state_q == seq_pkg::ST_LOCK ##1 state_q == seq_pkg::ST_SOFT);
endmodule

// ==== mcu_model.sv ====
/*
  Behavioural system microcontroller that drives the shared enable and fault pin.
  Assumes the device sinks the pin only while its output enable is high.
*/
`timescale 1ns/1ps
module mcu_model (
  // Host intent
  input wire logic enable_cmd,
  input wire logic direct_tie,
  // Device side of the pin
  input wire logic dev_o,
  input wire logic dev_oe,
  // Resolved wire level
  output logic pin_level
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Series resistor lets the sink win; a direct tie hides every fault pulse
  assign pin_level = (dev_oe && !direct_tie) ? dev_o : enable_cmd;
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench for the isolated supply sequencer with shortened timers.
  Assumes the pin level comes from the host model; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int PULSE = 20;
  localparam int RESTART = 30;
  localparam int DEGL = 4;
  logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1;
  logic enable_cmd = 1'b1, direct_tie = 1'b0;
  logic pin_level, line_o, line_oe, setpoint_5v5;
  seq_pkg::sense_t sense_raw;
  seq_pkg::stage_t stage;
  seq_pkg::state_t seq_state;
  logic [seq_pkg::SWEEP_W-1:0] sweep;
  int failures = 0, checks = 0, pulses = 0, n = 0, p0 = 0;
  logic low_ok;

  isolated_supply_fault_sequencer #(.FAULT_PULSE_CYC(PULSE), .RESTART_CYC(RESTART), .DEGLITCH_CYC(DEGL)) DUT (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .sense_raw(sense_raw),
    .enable_fault_line_i(pin_level), .enable_fault_line_o(line_o), .enable_fault_line_oe(line_oe),
    .stage(stage), .setpoint_5v5(setpoint_5v5), .spread_spectrum_sweep(sweep), .seq_state(seq_state));
  mcu_model partner (.enable_cmd(enable_cmd), .direct_tie(direct_tie), .dev_o(line_o), .dev_oe(line_oe),
    .pin_level(pin_level));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge line_oe) pulses++;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wait_state(input seq_pkg::state_t st, input int lim);
    n = 0;
    while (seq_state !== st && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    check("seq_state", seq_state, st);
  endtask
  task automatic bring_up(input logic sel);
    sense_raw.out_above_uvlo = 1'b0;
    sense_raw.setpoint_sel = sel;
    wait_state(seq_pkg::ST_SOFT, 20);
    step(5);
    check("soft duty_limit", stage.duty_limit, 1'b1);
    sense_raw.out_above_uvlo = 1'b1;
    wait_state(seq_pkg::ST_RUN, 10);
  endtask
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_setpoint();
    bring_up(1'b0);
    check("setpoint ground", setpoint_5v5, 1'b1);
    sense_raw.setpoint_sel = 1'b1;
    step(10);
    check("setpoint locked", setpoint_5v5, 1'b1);
    enable_cmd = 1'b0;
    step(5);
    check("disabled state", seq_state, seq_pkg::ST_OFF);
    check("disabled stage", stage.power_on, 1'b0);
    enable_cmd = 1'b1;
    bring_up(1'b1);
    check("setpoint output", setpoint_5v5, 1'b0);
  endtask

  task automatic t_burst();
    logic [3:0] last_sweep;
    sense_raw.out_above_upper = 1'b1;
    step(6);
    check("above band off", stage.power_on, 1'b0);
    sense_raw.out_above_upper = 1'b0;
    sense_raw.out_below_lower = 1'b1;
    n = 0;
    while (stage.power_on !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    check("burst start sweep low", sweep <= 4'h1, 1'b1);
    n = 0;
    while (stage.power_on === 1'b1 && n < 5000) begin
      last_sweep = sweep;
      step(1);
      n++;
    end
    check("on time limit", n >= seq_pkg::TON_MAX_CYC - 2 && n <= seq_pkg::TON_MAX_CYC + 2, 1'b1);
    check("sweep full span", last_sweep, 4'hf);
    check("overpower flag", stage.overpower, 1'b1);
    n = 0;
    while (stage.power_on !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    check("off time min", n >= seq_pkg::TOFF_MIN_CYC - 2 && n <= seq_pkg::TOFF_MIN_CYC + 2, 1'b1);
    sense_raw.out_below_lower = 1'b0;
    sense_raw.out_above_upper = 1'b1;
    step(6);
    check("upper stops burst", stage.power_on, 1'b0);
    check("overpower cleared", stage.overpower, 1'b0);
    sense_raw.out_above_upper = 1'b0;
  endtask

  task automatic t_uv();
    repeat (3) begin
      sense_raw.out_below_uvp = 1'b1;
      step(DEGL - 1);
      sense_raw.out_below_uvp = 1'b0;
      step(6);
    end
    check("glitch no shutdown", seq_state, seq_pkg::ST_RUN);
    p0 = pulses;
    sense_raw.out_below_uvp = 1'b1;
    wait_state(seq_pkg::ST_LIMIT, 8);
    // Stage flags follow the state one cycle later
    step(1);
    check("uv duty_limit", stage.duty_limit, 1'b1);
    wait_state(seq_pkg::ST_PULSE, DEGL + 10);
    n = 0;
    low_ok = 1'b1;
    while (line_oe === 1'b1 && n < 100) begin
      if (pin_level !== 1'b0) low_ok = 1'b0;
      step(1);
      n++;
    end
    check("pulse length", n, PULSE);
    check("pin low in pulse", low_ok, 1'b1);
    wait_state(seq_pkg::ST_WAIT, 3);
    wait_state(seq_pkg::ST_SOFT, RESTART + 5);
    check("restart wait", n >= RESTART - 2 && n <= RESTART + 2, 1'b1);
    wait_state(seq_pkg::ST_PULSE, DEGL + 30);
    check("hiccup pulses", pulses, p0 + 2);
    sense_raw.out_below_uvp = 1'b0;
    wait_state(seq_pkg::ST_RUN, PULSE + RESTART + 20);
  endtask

  task automatic t_ot();
    for (int i = 0; i < 2; i++) begin
      p0 = pulses;
      // Second pass with the pin tied hard: the report is hidden, restart must still run
      direct_tie = i == 1;
      if (i == 0) sense_raw.primary_overtemp_threshold = 1'b1;
      else sense_raw.secondary_overtemp_threshold = 1'b1;
      wait_state(seq_pkg::ST_PULSE, DEGL + 30);
      check("ot sink active", line_oe, 1'b1);
      step(1);
      check("ot stage off", stage.power_on, 1'b0);
      check("ot pulse", pulses, p0 + 1);
      sense_raw.primary_overtemp_threshold = 1'b0;
      sense_raw.secondary_overtemp_threshold = 1'b0;
      wait_state(seq_pkg::ST_WAIT, PULSE + 5);
      if (i == 1) begin
        // Clock enable low must freeze the restart timer
        ce = 1'b0;
        step(RESTART + 5);
        check("frozen wait", seq_state, seq_pkg::ST_WAIT);
        ce = 1'b1;
      end
      wait_state(seq_pkg::ST_RUN, RESTART + 20);
    end
    direct_tie = 1'b0;
  endtask

  task automatic t_ov();
    p0 = pulses;
    sense_raw.output_overvolt_rising = 1'b1;
    wait_state(seq_pkg::ST_LIMIT, 8);
    check("overvoltage_clamp", stage.clamp, 1'b1);
    wait_state(seq_pkg::ST_WAIT, DEGL + 10);
    check("ov no pulse", pulses, p0);
    sense_raw.output_overvolt_rising = 1'b0;
    wait_state(seq_pkg::ST_SOFT, RESTART + 5);
    check("ov restart wait", n >= RESTART - 2 && n <= RESTART + 2, 1'b1);
    wait_state(seq_pkg::ST_RUN, 10);
  endtask

  task automatic t_input();
    p0 = pulses;
    sense_raw.input_undervolt_falling = 1'b1;
    sense_raw.input_undervolt_rising = 1'b0;
    wait_state(seq_pkg::ST_LOCK, 8);
    step(1);
    check("uvlo stage off", stage.power_on, 1'b0);
    check("uvlo no pulse", pulses, p0);
    sense_raw.input_undervolt_falling = 1'b0;
    sense_raw.input_undervolt_rising = 1'b1;
    wait_state(seq_pkg::ST_SOFT, 8);
    wait_state(seq_pkg::ST_RUN, 10);
    sense_raw.input_overvolt_rising = 1'b1;
    sense_raw.input_overvolt_falling = 1'b0;
    wait_state(seq_pkg::ST_LOCK, 8);
    step(PULSE + 5);
    check("ovlo pulse", pulses, p0 + 1);
    sense_raw.input_overvolt_rising = 1'b0;
    sense_raw.input_overvolt_falling = 1'b1;
    wait_state(seq_pkg::ST_SOFT, 8);
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sense_raw = '0;
    sense_raw.input_undervolt_rising = 1'b1;
    sense_raw.input_overvolt_falling = 1'b1;
    step(3);
    srst = 1'b0;
    t_setpoint();
    t_burst();
    t_uv();
    t_ot();
    t_ov();
    t_input();
    conclude();
  end
  // About 5000 cycles are needed; 50000 leaves ample margin
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
